// File: pkg/twi_pkg.sv
// constants for the two-wire bus join and control block
package twi_pkg;
	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_CLKSEL  = 8'h08;
	localparam logic [7:0] OFS_EXTEN   = 8'h0C;
	localparam logic [7:0] OFS_FLAG    = 8'h10;
	localparam logic [7:0] OFS_SHIFT   = 8'h14;
	localparam logic [7:0] OFS_IRQ_ST  = 8'h18;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
	localparam logic [7:0] OFS_IRQ_EN  = 8'h20;
	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTL_ENABLE  = 7;
	localparam int CTL_RELEASE = 6;
	localparam int CTL_STOPIE  = 4;
	localparam int CTL_START   = 1;
	localparam int CTL_STOP    = 0;
	localparam int CLK_SPEED   = 3;
	localparam int STS_MASTER  = 7;
	localparam int STS_ACK     = 0;
	localparam int FLG_BUSY    = 6;
	localparam int FLG_INITST  = 1;
	localparam int EVT_STOP    = 0;
	localparam int EVT_BYTE    = 1;
	localparam int EVT_START   = 2;
	localparam int EVT_W       = 3;
	// ****************************************************************
	// bus codes
	// ****************************************************************
	localparam logic [4:0] EXT_CODE = 5'h1E;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0, ST_WAIT  = 4'h1, ST_START = 4'h2, ST_LOW   = 4'h3,
		ST_HIGH  = 4'h4, ST_PAUSE = 4'h5, ST_SP_LO = 4'h6, ST_SP_HI = 4'h7,
		ST_S_RX  = 4'h8, ST_S_ACK = 4'h9
	} state_type;
endpackage : twi_pkg

// File: verilog/twi_join_ctrl.sv
// two-wire bus controller: join, clock select, start/stop, reserved send
// Overview of operation
// RULE1 - enable with data low clock high: start seen
// RULE2 - extension code after that start gets acknowledged
// RULE3 - host clears stop irq enable before joining
// RULE4 - host sets enable, then waits for start
// RULE5 - host sets release within 4 to 80 clocks
// RULE6 - host programs clock selection before enabling
// RULE7 - clock change only while operation disabled
// RULE8 - no re-setting start/stop while still set
// RULE9 - host sets stop irq enable when reserving
// RULE10 - reserved send starts on data write after stop irq
// RULE11 - no stop irq: reserved send stays waiting
// RULE12 - host may poll master flag instead
// RULE13 - initial start enable set: busy reads 0 on enable
// RULE14 - initial start enable clear: busy reads 1 on enable
// RULE15 - start/stop request bits clear themselves when done
`timescale 1ns/100ps
module twi_join_ctrl #(
	parameter int HALF_BASE = 50
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// two-wire bus pins
	input  wire logic        serial_clock_line_i,
	output logic             serial_clock_line_o,
	output logic             serial_clock_line_oe_n,
	input  wire logic        serial_data_line_i,
	output logic             serial_data_line_o,
	output logic             serial_data_line_oe_n,
	// interrupt
	output logic             bus_irq
);
	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [1:0] scl_sync, sda_sync;
	logic       scl_d, sda_d;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_d    <= 1'h1;
			sda_d    <= 1'h1;
		end
		else
		begin
			scl_sync <= {scl_sync[0], serial_clock_line_i};
			sda_sync <= {sda_sync[0], serial_data_line_i};
			scl_d    <= scl_sync[1];
			sda_d    <= sda_sync[1];
		end
	end
	logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
	assign scl_s     = scl_sync[1];
	assign sda_s     = sda_sync[1];
	assign scl_rise  = scl_s & ~scl_d;
	assign scl_fall  = ~scl_s & scl_d;
	assign start_det = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

	// ****************************************************************
	// registers and link engine
	// ****************************************************************
	logic [7:0]  bus_control_reg, next_control;
	logic [3:0]  clock_select_reg, next_clksel;
	logic        clock_extension_bit, next_clkext;
	logic        initial_start_enable, next_initst;
	logic        bus_busy_flag, next_busy;
	logic [7:0]  shift_data_reg, next_shift;
	logic        ack_seen, next_ack_seen;
	logic [twi_pkg::EVT_W-1:0] irq_status, next_irq_status, irq_enable, next_irq_enable;
	logic        armed, next_armed;
	logic        en_d;
	twi_pkg::state_type state, next_state;
	logic [3:0]  bitn, next_bitn;
	logic [11:0] cnt, next_cnt, half;
	logic        next_pready, next_slverr, next_irq, next_scl_oe_n, next_sda_oe_n;
	logic [31:0] next_prdata;
	logic        wr, rd, en_rise, data_wr, master, ext_hit;
	logic [twi_pkg::EVT_W-1:0] evt;

	assign wr      = psel & penable & pready & pwrite;
	assign rd      = psel & penable & ~pready & ~pwrite;
	assign en_rise = bus_control_reg[twi_pkg::CTL_ENABLE] & ~en_d;
	assign data_wr = wr & (paddr == twi_pkg::OFS_SHIFT);
	assign master  = (state >= twi_pkg::ST_START) && (state <= twi_pkg::ST_SP_HI);
	assign ext_hit = shift_data_reg[7:3] == twi_pkg::EXT_CODE;
	assign half    = (12'(HALF_BASE) << clock_select_reg[1:0])
		>> ({1'h0, clock_select_reg[twi_pkg::CLK_SPEED]} + {1'h0, clock_extension_bit});

	always_comb
	begin
		next_control    = bus_control_reg;
		next_clksel     = clock_select_reg;
		next_clkext     = clock_extension_bit;
		next_initst     = initial_start_enable;
		next_busy       = bus_busy_flag;
		next_shift      = shift_data_reg;
		next_ack_seen   = ack_seen;
		next_irq_enable = irq_enable;
		next_armed      = armed;
		next_state      = state;
		next_bitn       = bitn;
		next_cnt        = cnt + 12'h001;
		evt             = '0;
		next_pready     = psel & penable & ~pready;
		next_slverr     = 1'h0;
		next_prdata     = prdata;
		// release request is a one-shot command
		next_control[twi_pkg::CTL_RELEASE] = 1'h0;
		if (wr)
		begin
			case (paddr)
				twi_pkg::OFS_CONTROL:
				begin
					next_control = pwdata[7:0];
					// RULE8 pending request is never re-armed
					next_control[twi_pkg::CTL_START] = bus_control_reg[twi_pkg::CTL_START]
						| pwdata[twi_pkg::CTL_START];
					next_control[twi_pkg::CTL_STOP] = bus_control_reg[twi_pkg::CTL_STOP]
						| pwdata[twi_pkg::CTL_STOP];
				end
				// RULE7 clock fields frozen while enabled
				twi_pkg::OFS_CLKSEL:
					if (!bus_control_reg[twi_pkg::CTL_ENABLE])
						next_clksel = {pwdata[3], 1'h0, pwdata[1:0]};
				twi_pkg::OFS_EXTEN:
					if (!bus_control_reg[twi_pkg::CTL_ENABLE])
						next_clkext = pwdata[0];
				twi_pkg::OFS_FLAG: next_initst = pwdata[twi_pkg::FLG_INITST];
				twi_pkg::OFS_SHIFT: next_shift = pwdata[7:0];
				twi_pkg::OFS_IRQ_EN: next_irq_enable = pwdata[twi_pkg::EVT_W-1:0];
				default: ;
			endcase
		end
		if (rd)
		begin
			case (paddr)
				twi_pkg::OFS_CONTROL: next_prdata = {24'h0, bus_control_reg};
				twi_pkg::OFS_STATUS:  next_prdata = {24'h0, master, 6'h0, ack_seen};
				twi_pkg::OFS_CLKSEL:  next_prdata = {28'h0, clock_select_reg};
				twi_pkg::OFS_EXTEN:   next_prdata = {31'h0, clock_extension_bit};
				twi_pkg::OFS_FLAG:
					next_prdata = {25'h0, bus_busy_flag, 4'h0, initial_start_enable, 1'h0};
				twi_pkg::OFS_SHIFT:   next_prdata = {24'h0, shift_data_reg};
				twi_pkg::OFS_IRQ_ST:  next_prdata = {29'h0, irq_status};
				twi_pkg::OFS_IRQ_CLR: next_prdata = 32'h0;
				twi_pkg::OFS_IRQ_EN:  next_prdata = {29'h0, irq_enable};
				default:
				begin
					next_prdata = 32'h0;
					next_slverr = 1'h1;
				end
			endcase
		end
		if (psel & penable & ~pready & pwrite && paddr > twi_pkg::OFS_IRQ_EN)
			next_slverr = 1'h1;

		// bus busy tracking
		if (start_det)
			next_busy = 1'h1;
		if (stop_det)
			next_busy = 1'h0;
		// RULE13 RULE14 busy forced on enable
		if (en_rise)
			next_busy = ~initial_start_enable;
		if (stop_det && bus_control_reg[twi_pkg::CTL_STOPIE])
			evt[twi_pkg::EVT_STOP] = 1'h1;

		case (state)
			twi_pkg::ST_IDLE:
			begin
				// RULE1 enable during traffic counts as start
				if (start_det || (en_rise && !sda_s && scl_s))
				begin
					next_state = twi_pkg::ST_S_RX;
					next_bitn  = 4'h0;
					evt[twi_pkg::EVT_START] = 1'h1;
				end
				else if (bus_control_reg[twi_pkg::CTL_START])
				begin
					next_cnt = 12'h000;
					// RULE15 reserved request resolved here
					next_control[twi_pkg::CTL_START] = 1'h0;
					next_armed = 1'h0;
					next_state = bus_busy_flag ? twi_pkg::ST_WAIT : twi_pkg::ST_START;
				end
				else if (bus_control_reg[twi_pkg::CTL_STOP])
				begin
					next_cnt   = 12'h000;
					next_state = twi_pkg::ST_SP_LO;
				end
			end
			twi_pkg::ST_WAIT:
			begin
				// RULE11 without stop irq the wait never ends
				if (stop_det && bus_control_reg[twi_pkg::CTL_STOPIE])
					next_armed = 1'h1;
				// RULE10 data write after stop irq starts send
				if (armed && data_wr)
				begin
					next_cnt   = 12'h000;
					next_state = twi_pkg::ST_START;
				end
			end
			twi_pkg::ST_START:
				if (cnt >= half)
				begin
					next_cnt   = 12'h000;
					next_bitn  = 4'h0;
					// RULE15 start generated
					next_control[twi_pkg::CTL_START] = 1'h0;
					next_state = twi_pkg::ST_LOW;
				end
			twi_pkg::ST_LOW:
				if (cnt >= half)
				begin
					next_cnt   = 12'h000;
					next_state = twi_pkg::ST_HIGH;
				end
			twi_pkg::ST_HIGH:
				// clock stretching: keep the count at zero until the line is really high
				if (!scl_s)
					next_cnt = 12'h000;
				else if (cnt >= half)
				begin
					next_cnt = 12'h000;
					if (bitn == twi_pkg::BITS_PER_BYTE)
					begin
						next_ack_seen = ~sda_s;
						evt[twi_pkg::EVT_BYTE] = 1'h1;
						next_state = twi_pkg::ST_PAUSE;
					end
					else
					begin
						next_shift = {shift_data_reg[6:0], sda_s};
						next_bitn  = bitn + 4'h1;
						next_state = twi_pkg::ST_LOW;
					end
				end
			twi_pkg::ST_PAUSE:
				if (bus_control_reg[twi_pkg::CTL_STOP])
				begin
					next_cnt   = 12'h000;
					next_state = twi_pkg::ST_SP_LO;
				end
				else if (data_wr)
				begin
					next_cnt   = 12'h000;
					next_bitn  = 4'h0;
					next_state = twi_pkg::ST_LOW;
				end
			twi_pkg::ST_SP_LO:
				if (cnt >= half)
				begin
					next_cnt   = 12'h000;
					next_state = twi_pkg::ST_SP_HI;
				end
			twi_pkg::ST_SP_HI:
				if (cnt >= half)
				begin
					// RULE15 stop generated
					next_control[twi_pkg::CTL_STOP] = 1'h0;
					next_state = twi_pkg::ST_IDLE;
				end
			twi_pkg::ST_S_RX:
				if (bus_control_reg[twi_pkg::CTL_RELEASE] || stop_det)
					next_state = twi_pkg::ST_IDLE;
				else if (scl_rise && bitn != twi_pkg::BITS_PER_BYTE)
				begin
					next_shift = {shift_data_reg[6:0], sda_s};
					next_bitn  = bitn + 4'h1;
				end
				else if (scl_fall && bitn == twi_pkg::BITS_PER_BYTE)
					// RULE2 extension code is acknowledged
					next_state = ext_hit ? twi_pkg::ST_S_ACK : twi_pkg::ST_IDLE;
			twi_pkg::ST_S_ACK:
				if (scl_fall || bus_control_reg[twi_pkg::CTL_RELEASE])
					next_state = twi_pkg::ST_IDLE;
			default: next_state = twi_pkg::ST_IDLE;
		endcase

		// operation enable low acts as a local reset of the engine
		if (!bus_control_reg[twi_pkg::CTL_ENABLE])
		begin
			next_state = twi_pkg::ST_IDLE;
			next_armed = 1'h0;
			next_control[twi_pkg::CTL_START] = 1'h0;
			next_control[twi_pkg::CTL_STOP] = 1'h0;
			evt = '0;
		end
		// set wins over a clear in the same cycle
		next_irq_status = irq_status;
		if (wr && paddr == twi_pkg::OFS_IRQ_CLR)
			next_irq_status = irq_status & ~pwdata[twi_pkg::EVT_W-1:0];
		next_irq_status = next_irq_status | evt;
		next_irq = |(next_irq_status & next_irq_enable);
		next_scl_oe_n = !(next_state == twi_pkg::ST_LOW || next_state == twi_pkg::ST_PAUSE
			|| next_state == twi_pkg::ST_SP_LO);
		next_sda_oe_n = !(next_state == twi_pkg::ST_START || next_state == twi_pkg::ST_SP_LO
			|| next_state == twi_pkg::ST_SP_HI || next_state == twi_pkg::ST_S_ACK
			|| ((next_state == twi_pkg::ST_LOW || next_state == twi_pkg::ST_HIGH)
			&& next_bitn != twi_pkg::BITS_PER_BYTE && !next_shift[7]));
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus_control_reg        <= 8'h00;
			clock_select_reg       <= 4'h0;
			clock_extension_bit    <= 1'h0;
			initial_start_enable   <= 1'h0;
			bus_busy_flag          <= 1'h0;
			shift_data_reg         <= 8'h00;
			ack_seen               <= 1'h0;
			irq_status             <= '0;
			irq_enable             <= '0;
			armed                  <= 1'h0;
			en_d                   <= 1'h0;
			state                  <= twi_pkg::ST_IDLE;
			bitn                   <= 4'h0;
			cnt                    <= 12'h000;
			pready                 <= 1'h0;
			prdata                 <= 32'h0;
			pslverr                <= 1'h0;
			bus_irq                <= 1'h0;
			serial_clock_line_o    <= 1'h0;
			serial_clock_line_oe_n <= 1'h1;
			serial_data_line_o     <= 1'h0;
			serial_data_line_oe_n  <= 1'h1;
		end
		else
		begin
			bus_control_reg        <= next_control;
			clock_select_reg       <= next_clksel;
			clock_extension_bit    <= next_clkext;
			initial_start_enable   <= next_initst;
			bus_busy_flag          <= next_busy;
			shift_data_reg         <= next_shift;
			ack_seen               <= next_ack_seen;
			irq_status             <= next_irq_status;
			irq_enable             <= next_irq_enable;
			armed                  <= next_armed;
			en_d                   <= bus_control_reg[twi_pkg::CTL_ENABLE];
			state                  <= next_state;
			bitn                   <= next_bitn;
			cnt                    <= next_cnt;
			pready                 <= next_pready;
			prdata                 <= next_prdata;
			pslverr                <= next_slverr;
			bus_irq                <= next_irq;
			serial_clock_line_o    <= 1'h0;
			serial_clock_line_oe_n <= next_scl_oe_n;
			serial_data_line_o     <= 1'h0;
			serial_data_line_oe_n  <= next_sda_oe_n;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	sequence s_enable_in_traffic;
		state == twi_pkg::ST_IDLE && en_rise && !sda_s && scl_s;
	endsequence
	property p_join_start;
		@(posedge clk) disable iff (!rst_n)
		s_enable_in_traffic |=> state == twi_pkg::ST_S_RX ##0 irq_status[twi_pkg::EVT_START];
	endproperty
	a_join_start: assert property (p_join_start) else $error("start not seen on join"); // RULE1
	property p_ext_ack;
		@(posedge clk) disable iff (!rst_n)
		(state == twi_pkg::ST_S_RX && bitn == twi_pkg::BITS_PER_BYTE && scl_fall && ext_hit
			&& !stop_det
			&& !bus_control_reg[twi_pkg::CTL_RELEASE] && bus_control_reg[twi_pkg::CTL_ENABLE])
			|=> !serial_data_line_oe_n;
	endproperty
	a_ext_ack: assert property (p_ext_ack) else $error("extension code not acked"); // RULE2
	property p_reserved_go;
		@(posedge clk) disable iff (!rst_n)
		(state == twi_pkg::ST_WAIT && armed && data_wr && bus_control_reg[twi_pkg::CTL_ENABLE])
			|=> state == twi_pkg::ST_START ##1 !serial_data_line_oe_n;
	endproperty
	a_reserved_go: assert property (p_reserved_go) else $error("reserved send not started"); // RULE10
	property p_wait_stays;
		@(posedge clk) disable iff (!rst_n)
		(state == twi_pkg::ST_WAIT && !armed && !bus_control_reg[twi_pkg::CTL_STOPIE]
			&& bus_control_reg[twi_pkg::CTL_ENABLE]) |=> state == twi_pkg::ST_WAIT && !armed;
	endproperty
	a_wait_stays: assert property (p_wait_stays) else $error("wait left without stop irq"); // RULE11
	property p_busy_free;
		@(posedge clk) disable iff (!rst_n)
		(en_rise && initial_start_enable) |=> !bus_busy_flag;
	endproperty
	a_busy_free: assert property (p_busy_free) else $error("busy not released on enable"); // RULE13
	property p_busy_set;
		@(posedge clk) disable iff (!rst_n)
		(en_rise && !initial_start_enable) |=> bus_busy_flag;
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy not set on enable"); // RULE14
	property p_start_clear;
		@(posedge clk) disable iff (!rst_n)
		(state == twi_pkg::ST_START && cnt >= half) |=> !bus_control_reg[twi_pkg::CTL_START]
			##0 !serial_clock_line_oe_n;
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("start request kept"); // RULE15
	property p_stop_clear;
		@(posedge clk) disable iff (!rst_n)
		(state == twi_pkg::ST_SP_HI && cnt >= half && bus_control_reg[twi_pkg::CTL_ENABLE])
			|=> !bus_control_reg[twi_pkg::CTL_STOP] && serial_data_line_oe_n;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stop request kept"); // RULE15
endmodule : twi_join_ctrl

// File: bench/twi_peer.sv
// behavioural peer master sharing the two-wire bus
`timescale 1ns/100ps
module twi_peer #(
	parameter time HALF = 200
) (
	// resolved bus levels
	input  wire logic scl,
	input  wire logic sda,
	// open-drain pulls, high pulls the line low
	output logic      scl_low,
	output logic      sda_low
);
	logic dut_acked;
	initial
	begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		dut_acked = 1'b0;
	end
	// data falls with clock high
	task automatic start_cond();
		sda_low = 1'b1;
		#HALF;
	endtask : start_cond
	// clock toggles only inside the frame; ninth bit released for the ack
	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 9; i++)
		begin
			scl_low = 1'b1;
			#(HALF/2);
			sda_low = (i < 8) ? ~b[7-i] : 1'b0;
			#(HALF/2);
			scl_low = 1'b0;
			#(HALF/2);
			if (i == 8)
				dut_acked = ~sda;
			#(HALF/2);
		end
		scl_low = 1'b1;
		sda_low = 1'b1;
		#HALF;
	endtask : send_byte
	// data rises with clock high
	task automatic stop_cond();
		scl_low = 1'b0;
		#HALF;
		sda_low = 1'b0;
		#HALF;
	endtask : stop_cond
endmodule : twi_peer

// File: bench/testbench.sv
// self-checking bench for the two-wire join and control block
`timescale 1ns/100ps
module testbench;
	localparam logic [7:0] CTL = twi_pkg::OFS_CONTROL;
	localparam logic [7:0] CKS = twi_pkg::OFS_CLKSEL;
	localparam logic [7:0] FLG = twi_pkg::OFS_FLAG;
	localparam logic [7:0] IST = twi_pkg::OFS_IRQ_ST;
	localparam logic [7:0] ICL = twi_pkg::OFS_IRQ_CLR;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, bus_irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        scl_o, scl_oe_n, sda_o, sda_oe_n, p_scl, p_sda, perr;
	wire         scl = (scl_oe_n | scl_o) & ~p_scl;
	wire         sda = (sda_oe_n | sda_o) & ~p_sda;
	int          err_count, samples_checked, cycles;
	// falls of the data enable, counted here only; scenarios take a snapshot
	int          sda_falls, base_falls;
	twi_join_ctrl #(.HALF_BASE(2)) twi_join_ctrl_i (.clk(clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.serial_clock_line_i(scl), .serial_clock_line_o(scl_o),
		.serial_clock_line_oe_n(scl_oe_n), .serial_data_line_i(sda),
		.serial_data_line_o(sda_o), .serial_data_line_oe_n(sda_oe_n),
		.bus_irq(bus_irq));
	twi_peer twi_peer_i (.scl(scl), .sda(sda), .scl_low(p_scl), .sda_low(p_sda));
	initial
		clk = 1'b0;
	always #25 clk = ~clk;
	always @(negedge sda_oe_n) sda_falls++;
	// hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			err_count++;
			complete_run();
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// answer and read data are taken at the rising edge that sees pready
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic poll(input logic [7:0] a, input logic [31:0] m, exp);
		for (int i = 0; i < 300; i++)
		begin
			apb(1'b0, a, 32'h0);
			if ((rd & m) === exp)
				break;
		end
		check("poll", rd & m, exp);
	endtask : poll
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	initial
	begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{err_count, samples_checked} = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, CTL, 32'h0);
		check("ctl_reset", rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped", perr, 1'b1);
		apb(1'b1, CKS, 32'h1);
		apb(1'b1, CTL, 32'h80);
		poll(FLG, 32'h40, 32'h40);
		apb(1'b1, CKS, 32'h0);
		poll(CKS, 32'hB, 32'h1);
		// join a busy bus, with and without release
		for (int rel = 0; rel < 2; rel++)
		begin
			apb(1'b1, CTL, 32'h0);
			apb(1'b1, ICL, 32'h7);
			twi_peer_i.start_cond();
			apb(1'b1, CTL, 32'h80);
			poll(IST, 32'h4, 32'h4);
			if (rel == 1)
				apb(1'b1, CTL, 32'hC0);
			twi_peer_i.send_byte(8'hF0);
			check("ext_ack", twi_peer_i.dut_acked, rel == 0);
			twi_peer_i.stop_cond();
		end
		// free bus on enable, then a plain master byte
		apb(1'b1, CTL, 32'h0);
		apb(1'b1, FLG, 32'h2);
		apb(1'b1, CTL, 32'h80);
		poll(FLG, 32'h40, 32'h0);
		apb(1'b1, twi_pkg::OFS_SHIFT, 32'h3C);
		apb(1'b1, CTL, 32'h82);
		poll(CTL, 32'h2, 32'h0);
		poll(IST, 32'h2, 32'h2);
		// master flag up in pause, no ack from the idle peer
		poll(twi_pkg::OFS_STATUS, 32'h81, 32'h80);
		apb(1'b1, CTL, 32'h81);
		poll(CTL, 32'h1, 32'h0);
		apb(1'b1, CTL, 32'h0);
		apb(1'b1, FLG, 32'h0);
		apb(1'b1, twi_pkg::OFS_IRQ_EN, 32'h1);
		// reserved send, stop irq disabled then enabled
		for (int ie = 0; ie < 2; ie++)
		begin
			apb(1'b1, CTL, 32'h0);
			apb(1'b1, ICL, 32'h7);
			apb(1'b1, CTL, 32'h80 | (ie << 4));
			apb(1'b1, CTL, 32'h82 | (ie << 4));
			twi_peer_i.start_cond();
			twi_peer_i.stop_cond();
			base_falls = sda_falls;
			apb(1'b1, twi_pkg::OFS_SHIFT, 32'hA5);
			repeat (150) @(posedge clk);
			check("reserved_send", sda_falls != base_falls, ie);
			// polled master flag shows whether the reserved send went out
			poll(twi_pkg::OFS_STATUS, 32'h80, ie << 7);
			check("stop_irq", bus_irq, ie);
		end
		apb(1'b1, CTL, 32'h91);
		poll(CTL, 32'h1, 32'h0);
		apb(1'b1, ICL, 32'h1);
		repeat (3) @(posedge clk);
		check("irq_cleared", bus_irq, 1'b0);
		complete_run();
	end
endmodule : testbench
